// ---- rtl/edo_blink.sv ----
// edo_blink.sv - divider giving a square wave for a blinking indicator
// assumes: one clock, synchronous active low reset
`timescale 1ns/1ps
`include "edo_map.svh"

module edo_blink #(
  parameter int HALF_CYC = `EDO_BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic blink
);

  localparam int CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic blink_reg;

  // a zero half period would leave the counter with no bits
  if (HALF_CYC < 1) begin
    $error("edo_blink: HALF_CYC must be at least 1");
  end

  // terminal count toggles the phase; enable pulse style, one clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (cnt_reg == CW'(HALF_CYC - 1)) begin
      cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign blink = blink_reg;

endmodule

// ---- rtl/edo_map.svh ----
// edo_map.svh - offsets, field positions, reset values and timing counts
// assumes: included by bare name from rtl files; definitions only
`ifndef EDO_MAP_SVH
`define EDO_MAP_SVH

// ----------------------------------------
// process image layout
// ----------------------------------------
`define EDO_OUT_OFFSET 8'h00
`define EDO_OUT_RESET 8'h00
`define EDO_NUM_CH 8
`define EDO_IN_BYTES 0

// ----------------------------------------
// fieldbus object addressing
// ----------------------------------------
`define EDO_CO_INDEX 16'h6200
`define EDO_CO_SUB_BYTE 8'h00
`define EDO_EC_SUB_FIRST 8'h01
`define EDO_EC_SUB_LAST 8'h08

// ----------------------------------------
// timing
// ----------------------------------------
`define EDO_CLK_HZ 100000000
`define EDO_BLINK_HZ 2
// half period of the blink in clock cycles
`define EDO_BLINK_HALF_CYC (`EDO_CLK_HZ / (`EDO_BLINK_HZ * 2))

`endif

// ---- rtl/edo_pkg.sv ----
// edo_pkg.sv - types for the eight channel digital output block
// assumes: constants come from edo_map.svh
package edo_pkg;

  // health inputs gathered as one carrier
  typedef struct packed {
    logic bus_power_ok;
    logic bus_comm_ok;
    logic overload;
    logic short_circuit;
    logic overheat;
    logic config_error;
  } edo_health_s;

  // indicator outputs
  typedef struct packed {
    logic run_indicator;
    logic fault_indicator;
    logic [7:0] channel_indicator;
  } edo_leds_s;

  // overall module condition decoded for the indicators
  typedef enum logic [2:0] {
    EDO_NO_POWER,
    EDO_OK,
    EDO_ERR_COMM_OK,
    EDO_ERR_NO_COMM,
    EDO_IDLE_NO_COMM
  } edo_cond_e;

endpackage

// ---- rtl/edo_top.sv ----
// edo_top.sv - eight channel digital output with status indicators
// assumes: the bus interface delivers a one-cycle write strobe with the
// output byte, and health flags arrive as pins from other clock domains
// assumes: one clock, reset synchronous and active low
// ----------------------------------------
// Overview of operation
// RQ1 - host writes one byte; bit n drives output channel n
// RQ2 - no input bytes; data flows only from host to outputs
// RQ3 - byte reachable at index 6200h; channels as subindex 01h to 08h (subindex writes are taken under any index, not only 6200h)
// RQ4 - channel indicator follows its output level
// RQ5 - comm ok and no error: run on, fault off
// RQ6 - comm ok with overload, short or overheat: run and fault on
// RQ7 - no comm with error: run off, fault on
// RQ8 - bus power failed: run and fault both off
// RQ9 - configuration error: fault blinks at 2 Hz
// RQ10 - outputs held low after reset until first byte written
// ----------------------------------------
`timescale 1ns/1ps
`include "edo_map.svh"

module edo_top #(
  parameter int NUM_CH = `EDO_NUM_CH,
  parameter int BLINK_HALF_CYC = `EDO_BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_wr,
  input wire logic [7:0] out_addr,
  input wire logic [7:0] output_state_byte,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  input wire logic [7:0] obj_data,
  input wire edo_pkg::edo_health_s health,
  output logic [7:0] dout,
  output edo_pkg::edo_leds_s leds,
  output logic [7:0] input_bytes_used,
  output logic outputs_valid
);

  // only the eight channel image is implemented; refuse other widths
  if (NUM_CH != 8) begin
    $error("edo_top: only eight channels are supported");
  end
  // the blink divider needs at least one cycle per phase
  if (BLINK_HALF_CYC < 1) begin
    $error("edo_top: BLINK_HALF_CYC must be at least 1");
  end

  // ----------------------------------------
  // health pin synchronisers
  // ----------------------------------------
  localparam int HW = $bits(edo_pkg::edo_health_s);
  logic [HW-1:0] sync1_reg, sync2_reg, sync3_reg;
  edo_pkg::edo_health_s health_reg;

  // three stages; a change counts once stages two and three agree
  // reset value zero reads as bus power failed, so lamps stay dark until pins settle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= health;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // per-bit agreement filter keeps glitches off the indicators
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      health_reg <= '0;
    end else begin
      for (int i = 0; i < HW; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          health_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // ----------------------------------------
  // output image
  // ----------------------------------------
  logic [7:0] out_reg;
  logic valid_reg;
  logic img_wr;
  logic [7:0] img_next;

  // bit mask for one fieldbus subindex, channel 0 at first subindex
  // out of range subindex gives an empty mask, which the caller treats as no write
  function automatic logic [7:0] sub_mask(input logic [7:0] sub);
    logic [7:0] m;
    m = 8'h00;
    if (sub >= `EDO_EC_SUB_FIRST && sub <= `EDO_EC_SUB_LAST) begin
      m = 8'h01 << 3'(sub - `EDO_EC_SUB_FIRST);
    end
    return m;
  endfunction

  // merge process image write and object writes into one next value
  // process image write has priority when both strobes meet in one cycle
  always_comb begin
    img_wr = 1'b0;
    img_next = out_reg;
    // RQ1 byte write
    if (out_wr && out_addr == `EDO_OUT_OFFSET) begin
      img_wr = 1'b1;
      img_next = output_state_byte;
    // RQ3 index 6200h
    end else if (obj_wr && obj_index == `EDO_CO_INDEX && obj_subindex == `EDO_CO_SUB_BYTE) begin
      img_wr = 1'b1;
      img_next = obj_data;
    // RQ3 per-channel subindex
    end else if (obj_wr && sub_mask(obj_subindex) != 8'h00) begin
      img_wr = 1'b1;
      img_next = obj_data[0] ? (out_reg | sub_mask(obj_subindex))
                             : (out_reg & ~sub_mask(obj_subindex));
    end
  end

  // an accepted write sets outputs_valid for good; only reset clears it
  // RQ10 outputs low until written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= `EDO_OUT_RESET;
      valid_reg <= 1'b0;
    end else if (img_wr) begin
      out_reg <= img_next;
      valid_reg <= 1'b1;
    end
  end

  // RQ1 drive channels from image
  assign dout = out_reg;
  assign outputs_valid = valid_reg;
  // the block answers no reads, so the host input area stays empty
  // RQ2 no input area used
  assign input_bytes_used = 8'(`EDO_IN_BYTES);

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  logic blink;
  edo_pkg::edo_cond_e cond;
  logic any_err;
  edo_pkg::edo_leds_s leds_reg;

  edo_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) edo_blink_inst (
    .clk(clk),
    .rst_n(rst_n),
    .blink(blink)
  );

  // any one of the three load faults counts as a module error
  assign any_err = health_reg.overload | health_reg.short_circuit | health_reg.overheat;

  // decode module condition, power failure first
  // no comm without error is not in the lamp table; both lamps stay dark then, except fault blinks on a config error
  always_comb begin
    if (!health_reg.bus_power_ok) begin
      cond = edo_pkg::EDO_NO_POWER;
    end else if (health_reg.bus_comm_ok && !any_err) begin
      cond = edo_pkg::EDO_OK;
    end else if (health_reg.bus_comm_ok) begin
      cond = edo_pkg::EDO_ERR_COMM_OK;
    end else if (any_err) begin
      cond = edo_pkg::EDO_ERR_NO_COMM;
    end else begin
      cond = edo_pkg::EDO_IDLE_NO_COMM;
    end
  end

  // registered indicators; config blink overrides the fault lamp only
  // channel lamps lag dout by one cycle, far below anything visible
  // divider free-runs, so the first blink phase after a config error may be short
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leds_reg <= '0;
    end else begin
      // RQ4 channel lamps follow outputs
      leds_reg.channel_indicator <= out_reg;
      case (cond)
        // RQ8 no bus power
        edo_pkg::EDO_NO_POWER: begin
          leds_reg.run_indicator <= 1'b0;
          leds_reg.fault_indicator <= 1'b0;
        end
        // RQ5 healthy module
        edo_pkg::EDO_OK: begin
          leds_reg.run_indicator <= 1'b1;
          leds_reg.fault_indicator <= 1'b0;
        end
        // RQ6 error with comm
        edo_pkg::EDO_ERR_COMM_OK: begin
          leds_reg.run_indicator <= 1'b1;
          leds_reg.fault_indicator <= 1'b1;
        end
        // RQ7 error without comm
        edo_pkg::EDO_ERR_NO_COMM: begin
          leds_reg.run_indicator <= 1'b0;
          leds_reg.fault_indicator <= 1'b1;
        end
        default: begin
          // no comm and no error: run dark, nothing to report
          leds_reg.run_indicator <= 1'b0;
          leds_reg.fault_indicator <= 1'b0;
        end
      endcase
      // RQ9 config error blink
      if (health_reg.config_error && health_reg.bus_power_ok) begin
        leds_reg.fault_indicator <= blink;
      end
    end
  end

  // indicators leave straight from flip-flops
  assign leds = leds_reg;

endmodule

// ---- testbench/edo_host.sv ----
// bus head model writing the output image of edo_top
// assumes: shares clk; one idle cycle between strobes
`timescale 1ns/1ps
module edo_host (
  input wire logic clk,
  output logic out_wr,
  output logic [7:0] out_addr,
  output logic [7:0] output_state_byte,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [7:0] obj_subindex,
  output logic [7:0] obj_data
);
  initial {out_wr, out_addr, output_state_byte, obj_wr, obj_index, obj_subindex, obj_data} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    out_addr = a;
    output_state_byte = d;
    out_wr = 1'b1;
    @(posedge clk) #1;
    out_wr = 1'b0;
    output_state_byte = ~d; // released data is garbage, not the last value
  endtask
  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic [7:0] d);
    @(posedge clk) #1;
    obj_index = i;
    obj_subindex = s;
    obj_data = d;
    obj_wr = 1'b1;
    @(posedge clk) #1;
    obj_wr = 1'b0;
    obj_data = ~d;
  endtask
endmodule

// ---- testbench/edo_top_assertions.sv ----
// checker for edo_top, sees its ports only
// assumes: bound into edo_top with a short blink period
`timescale 1ns/1ps
module edo_top_assertions #(
  parameter int BLINK_HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_wr,
  input wire logic [7:0] out_addr,
  input wire logic [7:0] output_state_byte,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  input wire logic [7:0] obj_data,
  input wire edo_pkg::edo_health_s health,
  input wire logic [7:0] dout,
  input wire edo_pkg::edo_leds_s leds,
  input wire logic [7:0] input_bytes_used,
  input wire logic outputs_valid
);
  // health windows need 8 settled cycles, the pins cross a 5 stage path
  localparam int BW = BLINK_HALF_CYC + 2;
  wire logic err = health.overload | health.short_circuit | health.overheat;
  wire logic pc = health.bus_power_ok & !health.config_error;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WR_BYTE: assert property (out_wr && out_addr == 8'h00 |=> dout == $past(output_state_byte))
    else $error("byte write lost");
  AST_HOLD: assert property (!out_wr && !obj_wr |=> $stable(dout))
    else $error("outputs moved without a write");
  AST_NO_IN: assert property (input_bytes_used == 8'h00)
    else $error("input bytes used");
  AST_OBJ_BYTE: assert property (obj_wr && !out_wr && obj_index == 16'h6200 && obj_subindex == 8'h00
    |=> dout == $past(obj_data))
    else $error("object byte write lost");
  AST_OBJ_BIT: assert property (obj_wr && !out_wr && obj_subindex inside {[8'h01:8'h08]}
    |=> dout[$past(obj_subindex) - 1] == $past(obj_data[0]))
    else $error("subindex bit write lost");
  AST_CH_LED: assert property (leds.channel_indicator == $past(dout))
    else $error("channel indicator off its output");
  AST_RUN: assert property ((pc && health.bus_comm_ok && $stable(health)) [*8] |-> leds[9:8] == {1'b1, err})
    else $error("run or fault wrong with bus up");
  AST_NO_COMM: assert property ((pc && !health.bus_comm_ok && err) [*8] |-> leds[9:8] == 2'b01)
    else $error("run or fault wrong with bus down");
  AST_NO_PWR: assert property ((!health.bus_power_ok) [*8] |-> leds[9:8] == 2'b00)
    else $error("indicator lit without power");
  AST_BLINK: assert property ((health.bus_power_ok && health.config_error) [*8]
    |-> ##[1:BW] $changed(leds.fault_indicator))
    else $error("fault indicator not blinking");
  AST_IDLE: assert property (!outputs_valid |-> dout == 8'h00)
    else $error("outputs driven before first write");
  cover property (out_wr && out_addr == 8'h00);
  cover property (obj_wr && obj_subindex == 8'h08);
  cover property (health.config_error [*8]);
endmodule
bind edo_top edo_top_assertions #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) edo_top_assertions_inst (.*);

// ---- testbench/edo_top_tb.sv ----
// directed test of edo_top
// assumes: edo_host writes, health pins driven here
`timescale 1ns/1ps
module edo_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  edo_pkg::edo_health_s health = '0;
  logic out_wr, obj_wr, outputs_valid;
  logic [7:0] out_addr, output_state_byte, obj_subindex, obj_data, dout, input_bytes_used;
  logic [15:0] obj_index;
  edo_pkg::edo_leds_s leds;
  logic [5:0] hv [5] = '{6'h30, 6'h38, 6'h24, 6'h32, 6'h1E};
  logic [1:0] ex [5] = '{2'b10, 2'b11, 2'b01, 2'b11, 2'b00};
  int n_errors = 0;
  int cmp_count = 0;
  int k;
  logic [7:0] v;
  always #5 clk = ~clk;
  edo_host edo_host_inst (.*);
  edo_top #(.BLINK_HALF_CYC(4)) edo_top_inst (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  // health settles through a short sync path, ten cycles covers it
  task automatic hw(input logic [5:0] h);
    @(posedge clk) #1;
    health = h;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic flips(output int n);
    logic f;
    n = 0;
    f = leds.fault_indicator;
    repeat (20) begin
      @(posedge clk) #1;
      n += (leds.fault_indicator !== f);
      f = leds.fault_indicator;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({dout, outputs_valid}, 9'h000);
    chk(input_bytes_used, 8'h00);
    $display("reset test done");
    for (k = 0; k < 9; k++) begin
      v = (k < 8) ? 8'h01 << k : 8'hA5;
      edo_host_inst.wr(8'h00, v);
      chk(dout, v);
      @(posedge clk) #1;
      chk(leds.channel_indicator, v);
    end
    chk(outputs_valid, 1'b1);
    edo_host_inst.wr(8'h01, 8'h5A);
    edo_host_inst.obj(16'h6201, 8'h00, 8'h5A);
    chk(dout, 8'hA5);
    edo_host_inst.obj(16'h6200, 8'h00, 8'h00);
    for (k = 1; k < 9; k++) begin
      edo_host_inst.obj(16'h6200, k[7:0], 8'h01);
      chk(dout, 16'h00FF >> (8 - k));
    end
    $display("write test done");
    for (k = 0; k < 5; k++) begin
      hw(hv[k]);
      chk(leds[9:8], ex[k]);
    end
    hw(6'h31);
    flips(k);
    chk(k, 5);
    hw(6'h01);
    flips(k);
    chk(k, 0);
    $display("indicator test done");
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({dout, outputs_valid}, 9'h000);
    chk(leds, 10'h000);
    edo_host_inst.wr(8'h00, 8'h3C);
    chk({dout, outputs_valid}, 9'h079);
    $display("second reset test done");
    tally_and_finish;
  end
  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end
endmodule
